// File: hmw_pkg.sv
// Purpose: Shared constants for the host memory window block
// Assumes: Register index times four gives the AHB byte address
// Notes:   Access type selects how data port reaches memory
`default_nettype none
package hmw_pkg;
   // Register indices
   localparam logic [3:0] IDX_ADDR_LOW   = 4'h2;
   localparam logic [3:0] IDX_ADDR_HIGH  = 4'h3;
   localparam logic [3:0] IDX_BYTE_LOW   = 4'h4;
   localparam logic [3:0] IDX_BYTE_ONE   = 4'h5;
   localparam logic [3:0] IDX_BYTE_TWO   = 4'h6;
   localparam logic [3:0] IDX_BYTE_HIGH  = 4'h7;
   localparam logic [3:0] IDX_FLAGS_LOW  = 4'h8;
   localparam logic [3:0] IDX_FLAGS_HIGH = 4'h9;
   localparam logic [3:0] IDX_EN_LOW     = 4'hA;
   localparam logic [3:0] IDX_EN_HIGH    = 4'hB;
   localparam logic [3:0] IDX_EVT_STAT   = 4'hD;
   localparam logic [3:0] IDX_EVT_MASK   = 4'hE;
   // Field positions
   localparam int ACC_POS       = 0;
   localparam int ADDR_LOW_POS  = 2;
   localparam int REGION_POS    = 7;
   localparam int FLAG_MBOX_POS = 0;
   localparam int EVT_MBOX_POS  = 0;
   localparam int EVT_MEM_POS   = 1;
   // Reset values
   localparam logic [31:0] DATA_RESET  = 32'h0000_0000;
   localparam logic [15:0] FLAGS_RESET = 16'h0000;
   localparam logic [15:0] EN_RESET    = 16'h0000;
   localparam logic [12:0] ADDR_RESET  = 13'h0000;
   localparam logic [1:0]  EVT_RESET   = 2'h0;
   // Data port access types
   typedef enum logic [1:0] {
      HMW_ACC_BYTE     = 2'b00,
      HMW_ACC_HALF     = 2'b01,
      HMW_ACC_WORD     = 2'b10,
      HMW_ACC_WORD_INC = 2'b11
   } hmw_access_type;
endpackage : hmw_pkg
`default_nettype wire

// File: hmw_flag_bank.sv
// Purpose: Sticky flag bank, set by controller, write-one clear by host
// Assumes: Set and clear inputs are one-cycle pulses
// Notes:   A set in the clearing cycle wins
`timescale 1ns/1ns
`default_nettype none
module hmw_flag_bank
   import hmw_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic [WIDTH-1:0] clr_req,
   input  wire logic [WIDTH-1:0] clr_perm,
   output logic      [WIDTH-1:0] flags
);
   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } hmw_bank_type;

   hmw_bank_type s_reg;
   hmw_bank_type s_next;

   initial begin
      if (WIDTH < 1 || WIDTH > 16) $error("hmw_flag_bank: WIDTH out of range");
   end

   // Clear only where permitted, set wins
   always_comb begin
      s_next = s_reg;
      s_next.flags = set_in | (s_reg.flags & ~(clr_req & clr_perm));
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg.flags <= FLAGS_RESET[WIDTH-1:0];
      end else begin
         s_reg <= s_next;
      end
   end

   assign flags = s_reg.flags;
endmodule : hmw_flag_bank
`default_nettype wire

// File: hmw_word_mem.sv
// Purpose: Controller memory reached through the data port
// Assumes: One access per cycle, read data one cycle later
// Notes:   Array content is not reset
`timescale 1ns/1ns
`default_nettype none
module hmw_word_mem
   import hmw_pkg::*;
#(
   parameter int AW = 8
) (
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          req,
   input  wire logic          we,
   input  wire logic [AW-1:0] idx,
   input  wire logic [3:0]    be,
   input  wire logic [31:0]   wdata,
   output logic      [31:0]   rdata
);
   typedef struct packed {
      logic [31:0] rdata;
   } hmw_mem_type;

   hmw_mem_type s_reg;
   hmw_mem_type s_next;
   logic [31:0] words [2**AW];

   initial begin
      if (AW < 1 || AW > 14) $error("hmw_word_mem: AW out of range");
   end

   // Read data capture
   always_comb begin
      s_next = s_reg;
      if (req && !we) begin
         s_next.rdata = words[idx];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg.rdata <= DATA_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // Byte lane writes, one process so the array has one writer
   always_ff @(posedge hclk) begin
      if (req && we) begin
         for (int g = 0; g < 4; g++) begin
            if (be[g]) begin
               words[idx][8*g +: 8] <= wdata[8*g +: 8];
            end
         end
      end
   end

   assign rdata = s_reg.rdata;
endmodule : hmw_word_mem
`default_nettype wire

// File: hmw_window.sv
// Purpose: Host data port, software flags and interrupt of memory window
// Assumes: AHB-Lite single word transfers, data in the low byte
// Notes:   Zero wait states, response always OKAY
//
// How it works
// - Data port is four byte registers, low byte first, then bytes one, two
// - Fourth byte register holds the top byte; all read/write, reset zero
// - Seven controller-set flags live in bits 7 to 1 of low flags
// - Eight more controller-set flags fill the high flags register
// - Host writing one to a flag in bits 15 to 1 clears it when clearing allowed
// - Host clear is ignored while controller's clear permission bit is zero
// - Controller mailbox write sets read-only flag bit 0 of low flags
// - Mailbox-written flag never reaches the interrupt; enable bit 0 has no effect on it
// - Flag raises interrupt only when its enable bit is one
// - Two-bit access type picks byte, halfword, word, word with increment
// - Memory address low two bits forced zero, word aligned in region
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module hmw_window
   import hmw_pkg::*;
#(
   parameter int MEM_AW = 8
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic [15:1] ctl_flag_set,
   input  wire logic [15:1] ctl_clear_enable,
   input  wire logic        ctl_mbox_write,
   input  wire logic        host_mbox_cleared,
   output logic             irq
);
   typedef struct packed {
      logic           ready;
      logic           resp;
      logic [31:0]    hrdata;
      logic           irq;
      hmw_access_type acc;
      logic           region;
      logic [12:0]    waddr;
      logic [31:0]    data;
      logic [15:0]    en;
      logic [1:0]     evt;
      logic [1:0]     evt_mask;
      logic           dp_valid;
      logic           dp_write;
      logic [3:0]     dp_idx;
      logic           rd_pend;
   } hmw_state_type;

   hmw_state_type s_reg;
   hmw_state_type s_next;
   logic [15:0]   flags;
   logic [15:0]   clr_req;
   logic          take;
   logic          hit;
   logic [3:0]    idx;
   logic [7:0]    wbyte;
   logic          dp_wr;
   logic          mem_req;
   logic          mem_we;
   logic [3:0]    mem_be;
   logic [13:0]   mem_word;
   logic [31:0]   mem_rdata;
   logic [7:0]    rd_mux;

   initial begin
      if (MEM_AW < 1 || MEM_AW > 14) $error("hmw_window: MEM_AW out of range");
   end

   // Address phase decode
   assign take  = hsel && hready && htrans[1];
   assign hit   = (haddr[31:6] == 26'h000_0000) && (haddr[1:0] == 2'b00);
   assign idx   = haddr[5:2];
   assign wbyte = hwdata[7:0];
   assign dp_wr = s_reg.dp_valid && s_reg.dp_write;

   // Word address, low two byte bits implied zero
   assign mem_word = {s_reg.region, s_reg.waddr};

   // Read multiplexer
   always_comb begin
      rd_mux = 8'h00;
      if (idx == IDX_ADDR_LOW) begin
         rd_mux = {s_reg.waddr[5:0], s_reg.acc};
      end else if (idx == IDX_ADDR_HIGH) begin
         rd_mux = {s_reg.region, s_reg.waddr[12:6]};
      end else if (idx == IDX_BYTE_LOW) begin
         rd_mux = s_reg.data[7:0];
      end else if (idx == IDX_BYTE_ONE) begin
         rd_mux = s_reg.data[15:8];
      end else if (idx == IDX_BYTE_TWO) begin
         rd_mux = s_reg.data[23:16];
      end else if (idx == IDX_BYTE_HIGH) begin
         rd_mux = s_reg.data[31:24];
      end else if (idx == IDX_FLAGS_LOW) begin
         rd_mux = flags[7:0];
      end else if (idx == IDX_FLAGS_HIGH) begin
         rd_mux = flags[15:8];
      end else if (idx == IDX_EN_LOW) begin
         rd_mux = s_reg.en[7:0];
      end else if (idx == IDX_EN_HIGH) begin
         rd_mux = s_reg.en[15:8];
      end else if (idx == IDX_EVT_STAT) begin
         rd_mux = {6'h00, s_reg.evt};
      end else if (idx == IDX_EVT_MASK) begin
         rd_mux = {6'h00, s_reg.evt_mask};
      end
   end

   // Host write-one clear requests; zeros leave flags alone
   always_comb begin
      clr_req = 16'h0000;
      clr_req[FLAG_MBOX_POS] = host_mbox_cleared;
      if (dp_wr && s_reg.dp_idx == IDX_FLAGS_LOW) begin
         clr_req[7:1] = wbyte[7:1];
      end else if (dp_wr && s_reg.dp_idx == IDX_FLAGS_HIGH) begin
         clr_req[15:8] = wbyte;
      end
   end

   // Memory request from data port, by access type
   always_comb begin
      mem_req = 1'b0;
      mem_we  = 1'b0;
      mem_be  = 4'h0;
      if (s_reg.dp_valid && !s_reg.dp_write && s_reg.dp_idx == IDX_BYTE_LOW) begin
         mem_req = 1'b1;
      end else if (dp_wr) begin
         case (s_reg.acc)
            HMW_ACC_BYTE: begin
               mem_req = (s_reg.dp_idx == IDX_BYTE_LOW);
               mem_be  = 4'h1;
            end
            HMW_ACC_HALF: begin
               mem_req = (s_reg.dp_idx == IDX_BYTE_ONE);
               mem_be  = 4'h3;
            end
            default: begin
               mem_req = (s_reg.dp_idx == IDX_BYTE_HIGH);
               mem_be  = 4'hF;
            end
         endcase
         mem_we = mem_req;
      end
   end

   // Next state
   always_comb begin
      s_next = s_reg;
      s_next.ready    = 1'b1;
      s_next.resp     = 1'b0;
      s_next.dp_valid = take && hit;
      s_next.dp_write = hwrite;
      s_next.dp_idx   = idx;
      s_next.rd_pend  = mem_req && !mem_we;
      // Read data registered in address phase
      if (take && !hwrite) begin
         s_next.hrdata = {24'h00_0000, hit ? rd_mux : 8'h00};
         if (hit && idx == IDX_EVT_STAT) begin
            s_next.evt = EVT_RESET;
         end
      end
      // Memory read result refills data port
      if (s_reg.rd_pend) begin
         s_next.data = mem_rdata;
      end
      // Register writes in data phase
      if (dp_wr) begin
         if (s_reg.dp_idx == IDX_ADDR_LOW) begin
            s_next.waddr[5:0] = wbyte[7:ADDR_LOW_POS];
            s_next.acc = hmw_access_type'(wbyte[ACC_POS +: 2]);
         end else if (s_reg.dp_idx == IDX_ADDR_HIGH) begin
            s_next.region = wbyte[REGION_POS];
            s_next.waddr[12:6] = wbyte[6:0];
         end else if (s_reg.dp_idx == IDX_BYTE_LOW) begin
            s_next.data[7:0] = wbyte;
         end else if (s_reg.dp_idx == IDX_BYTE_ONE) begin
            s_next.data[15:8] = wbyte;
         end else if (s_reg.dp_idx == IDX_BYTE_TWO) begin
            s_next.data[23:16] = wbyte;
         end else if (s_reg.dp_idx == IDX_BYTE_HIGH) begin
            s_next.data[31:24] = wbyte;
         end else if (s_reg.dp_idx == IDX_EN_LOW) begin
            s_next.en[7:0] = wbyte;
         end else if (s_reg.dp_idx == IDX_EN_HIGH) begin
            s_next.en[15:8] = wbyte;
         end else if (s_reg.dp_idx == IDX_EVT_MASK) begin
            s_next.evt_mask = wbyte[1:0];
         end
      end
      // Auto increment after each access in word with increment mode
      if (mem_req && s_reg.acc == HMW_ACC_WORD_INC) begin
         s_next.waddr = s_reg.waddr + 13'h0001;
      end
      // Events set after read clear, so set wins
      if (ctl_mbox_write) begin
         s_next.evt[EVT_MBOX_POS] = 1'b1;
      end
      if (s_reg.rd_pend || mem_we) begin
         s_next.evt[EVT_MEM_POS] = 1'b1;
      end
      // Mailbox flag bit 0 never reaches the interrupt
      s_next.irq = (|(flags[15:1] & s_reg.en[15:1]))
                   || (|(s_reg.evt & s_reg.evt_mask));
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg          <= '0;
         s_reg.ready    <= 1'b1;
         s_reg.acc      <= HMW_ACC_BYTE;
         s_reg.waddr    <= ADDR_RESET;
         s_reg.data     <= DATA_RESET;
         s_reg.en       <= EN_RESET;
         s_reg.evt      <= EVT_RESET;
         s_reg.evt_mask <= EVT_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // Software flags; bit 0 is the mailbox-written flag
   hmw_flag_bank #(
      .WIDTH (16)
   ) u_flags (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .set_in   ({ctl_flag_set, ctl_mbox_write}),
      .clr_req  (clr_req),
      .clr_perm ({ctl_clear_enable, 1'b1}),
      .flags    (flags)
   );

   // Controller memory
   hmw_word_mem #(
      .AW (MEM_AW)
   ) u_mem (
      .hclk    (hclk),
      .hresetn (hresetn),
      .req     (mem_req),
      .we      (mem_we),
      .idx     (mem_word[MEM_AW-1:0]),
      .be      (mem_be),
      .wdata   (s_next.data),
      .rdata   (mem_rdata)
   );

   assign hreadyout = s_reg.ready;
   assign hresp     = s_reg.resp;
   assign hrdata    = s_reg.hrdata;
   assign irq       = s_reg.irq;

   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_DATA_BYTE_TWO: assert property (
      dp_wr && s_reg.dp_idx == IDX_BYTE_TWO |=> s_reg.data[23:16] == $past(hwdata[7:0]))
      else $error("byte two write lost");
   AST_DATA_BYTE_HIGH: assert property (
      take && hit && !hwrite && idx == IDX_BYTE_HIGH
      |=> hrdata[7:0] == $past(s_reg.data[31:24]))
      else $error("top byte read wrong");
   AST_W1C_CLEAR: assert property (
      dp_wr && s_reg.dp_idx == IDX_FLAGS_HIGH && hwdata[0] && ctl_clear_enable[8]
      && !ctl_flag_set[8] |=> !flags[8])
      else $error("permitted clear ignored");
   AST_CLEAR_BLOCKED: assert property (
      dp_wr && s_reg.dp_idx == IDX_FLAGS_HIGH && !ctl_clear_enable[8] && flags[8]
      |=> flags[8])
      else $error("blocked clear took effect");
   AST_MBOX_SET: assert property (
      ctl_mbox_write |=> flags[0] ##0 s_reg.evt[EVT_MBOX_POS])
      else $error("mailbox flag not set");
   AST_MBOX_UNMASKED: assert property (
      flags[0] && (flags[15:1] & s_reg.en[15:1]) == 15'h0000
      && (s_reg.evt & s_reg.evt_mask) == 2'h0 |=> !irq)
      else $error("mailbox flag gated onto interrupt");
   AST_IRQ_ENABLED: assert property (
      |(flags[15:1] & s_reg.en[15:1]) |=> irq)
      else $error("enabled flag gave no interrupt");
   AST_WORD_INC: assert property (
      mem_req && s_reg.acc == HMW_ACC_WORD_INC && !dp_wr
      |=> s_reg.waddr == $past(s_reg.waddr) + 13'h0001)
      else $error("auto increment missed");
   AST_BYTE_LANE: assert property (
      mem_we && s_reg.acc == HMW_ACC_BYTE |-> mem_be == 4'h1 && s_reg.dp_idx == IDX_BYTE_LOW)
      else $error("byte access lane wrong");
   AST_NO_HOST_SET: assert property (
      (flags[15:1] & ~$past(flags[15:1]) & ~$past(ctl_flag_set)) == 15'h0000)
      else $error("flag set without controller");
   AST_MBOX_CLEAR: assert property (
      host_mbox_cleared && !ctl_mbox_write |=> !flags[0])
      else $error("mailbox flag not cleared");
   AST_LOW_W1C: assert property (
      dp_wr && s_reg.dp_idx == IDX_FLAGS_LOW && hwdata[1] && ctl_clear_enable[1]
      && !ctl_flag_set[1] |=> !flags[1])
      else $error("low flag clear ignored");
   AST_MBOX_READ_ONLY: assert property (
      dp_wr && s_reg.dp_idx == IDX_FLAGS_LOW && flags[0] && !host_mbox_cleared
      |=> flags[0])
      else $error("host write cleared mailbox flag");
   AST_ZERO_WRITE: assert property (
      dp_wr && s_reg.dp_idx == IDX_FLAGS_HIGH && hwdata[7:0] == 8'h00
      |=> flags[15:8] == ($past(flags[15:8]) | $past(ctl_flag_set[15:8])))
      else $error("zero write changed a flag");
   AST_FLAG_LOW_READ: assert property (
      take && hit && !hwrite && idx == IDX_FLAGS_LOW
      |=> hrdata == {24'h00_0000, $past(flags[7:0])})
      else $error("low flags read wrong");
   AST_HALF_LANE: assert property (
      mem_we && s_reg.acc == HMW_ACC_HALF |-> mem_be == 4'h3 && s_reg.dp_idx == IDX_BYTE_ONE)
      else $error("halfword access lane wrong");
   AST_WORD_LANE: assert property (
      mem_we && s_reg.acc[1] |-> mem_be == 4'hF && s_reg.dp_idx == IDX_BYTE_HIGH)
      else $error("word access lane wrong");
   AST_EVT_IRQ: assert property (
      |(s_reg.evt & s_reg.evt_mask) |=> irq)
      else $error("unmasked event gave no interrupt");
   AST_EVT_READ_CLEAR: assert property (
      take && hit && !hwrite && idx == IDX_EVT_STAT && !ctl_mbox_write
      && !s_reg.rd_pend && !mem_we |=> s_reg.evt == 2'h0)
      else $error("event status read did not clear");
   AST_BUS_OKAY: assert property (
      hreadyout && !hresp)
      else $error("bus answer not ready and okay");

   COV_BLOCKED: cover property (
      dp_wr && s_reg.dp_idx == IDX_FLAGS_LOW && !ctl_clear_enable[1] && flags[1]);
   COV_IRQ: cover property ($rose(irq));
   COV_WORD_INC: cover property (mem_we && s_reg.acc == HMW_ACC_WORD_INC);
   COV_EVT_IRQ: cover property ((s_reg.evt & s_reg.evt_mask) != 2'h0);
endmodule : hmw_window
`default_nettype wire

// File: hmw_host_model.sv
// Purpose: Host processor model issuing AHB-Lite single transfers
// Assumes: Caller enters each task just after a rising clock edge
// Notes:   Waits are bounded; ok goes low when hready never came
`timescale 1ns/1ns
`default_nettype none
module hmw_host_model (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output var  logic        hsel,
   output var  logic [31:0] haddr,
   output var  logic [1:0]  htrans,
   output var  logic        hwrite,
   output var  logic [2:0]  hsize,
   output var  logic [31:0] hwdata
);
   // Idle bus from time zero
   initial begin
      hsel   = 1'b0;
      haddr  = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize  = 3'b010;
      hwdata = 32'h0000_0000;
   end

   // Step edges until hready is seen high, bounded
   task automatic wait_ready(output bit ok);
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      ok = (hready === 1'b1);
   endtask : wait_ready

   // Address phase held to hready, then data phase held to hready
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q, output bit ok);
      bit ok_a;
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'b10;
      hwrite <= w;
      hsize  <= 3'b010;
      wait_ready(ok_a);
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready(ok);
      q  = hrdata;
      ok = ok & ok_a;
   endtask : xfer
endmodule : hmw_host_model
`default_nettype wire

// File: hmw_window_tb.sv
// Purpose: Self-checking bench for the host memory window block
// Assumes: Zero wait state slave, registers at index times four
// Notes:   Controller side is driven directly by the bench
`timescale 1ns/1ns
`default_nettype none
module hmw_window_tb;
   import hmw_pkg::*;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [15:1] ctl_flag_set;
   logic [15:1] ctl_clear_enable;
   logic        ctl_mbox_write;
   logic        host_mbox_cleared;
   logic        irq;
   int          fail_count;
   int          tests_run;

   // Host bus master
   hmw_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   hmw_window DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .ctl_flag_set(ctl_flag_set), .ctl_clear_enable(ctl_clear_enable),
      .ctl_mbox_write(ctl_mbox_write), .host_mbox_cleared(host_mbox_cleared), .irq(irq));

   // Clock, 8 ns period
   initial hclk = 1'b0;
   always #4 hclk = ~hclk;

   // Verdict and end of run
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Bus transfer by register index, hang ends the run
   task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d,
                      output logic [31:0] q);
      bit ok;
      host.xfer(w, 32'({i, 2'b00}), 32'(d), q, ok);
      if (!ok) begin
         fail_count++;
         $display("[ERR] %0t bus hang", $time);
         test_done();
      end
   endtask : bus

   task automatic wr(input logic [3:0] i, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, i, d, q);
   endtask : wr

   task automatic rd(input logic [3:0] i, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, i, 8'h00, q);
      chk(q, 32'(e));
      chk(32'(hresp), 32'h0000_0000);
      chk(32'(hreadyout), 32'h0000_0001);
   endtask : rd

   // One-cycle controller strobes
   task automatic pulse(input logic [15:0] v, input logic m, input logic c);
      ctl_flag_set      <= v[15:1];
      ctl_mbox_write    <= m;
      host_mbox_cleared <= c;
      @(posedge hclk);
      ctl_flag_set      <= '0;
      ctl_mbox_write    <= 1'b0;
      host_mbox_cleared <= 1'b0;
      @(posedge hclk);
   endtask : pulse

   // Interrupt check two edges after a change
   task automatic irq_is(input logic e);
      repeat (2) @(posedge hclk);
      chk(32'(irq), 32'(e));
   endtask : irq_is

   // Main sequence
   initial begin
      hresetn           = 1'b0;
      ctl_flag_set      = '0;
      ctl_clear_enable  = '0;
      ctl_mbox_write    = 1'b0;
      host_mbox_cleared = 1'b0;
      fail_count        = 0;
      tests_run         = 0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 15; i >= 0; i--) rd(4'(i), 8'h00);
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00);
      $display("test reset values done");
      wr(4'h4, 8'hA1);
      wr(4'h5, 8'hB2);
      wr(4'h6, 8'hC3);
      wr(4'h7, 8'hD4);
      rd(4'h7, 8'hD4);
      rd(4'h6, 8'hC3);
      rd(4'h5, 8'hB2);
      rd(4'h4, 8'hA1);
      $display("test data bytes done");
      wr(4'h2, 8'h0A);
      for (int i = 4; i < 8; i++) wr(4'(i), 8'(8'h11 * (i - 3)));
      wr(4'h2, 8'h08);
      wr(4'h4, 8'h5A);
      wr(4'h2, 8'h09);
      wr(4'h4, 8'h66);
      wr(4'h5, 8'h77);
      wr(4'h2, 8'h0E);
      for (int i = 4; i < 8; i++) wr(4'(i), 8'h00);
      wr(4'h2, 8'h0A);
      rd(4'h4, 8'h00);
      repeat (3) @(posedge hclk);
      rd(4'h7, 8'h44);
      rd(4'h6, 8'h33);
      rd(4'h5, 8'h77);
      rd(4'h4, 8'h66);
      wr(4'h2, 8'h0B);
      rd(4'h4, 8'h66);
      repeat (3) @(posedge hclk);
      rd(4'h2, 8'h0F);
      $display("test memory access done");
      pulse(16'hFFFE, 1'b0, 1'b0);
      rd(4'h8, 8'hFE);
      rd(4'h9, 8'hFF);
      wr(4'h8, 8'hFF);
      wr(4'h9, 8'hFF);
      rd(4'h8, 8'hFE);
      rd(4'h9, 8'hFF);
      ctl_clear_enable <= 15'h5555;
      wr(4'h8, 8'h00);
      wr(4'h9, 8'h00);
      rd(4'h8, 8'hFE);
      wr(4'h8, 8'hFF);
      wr(4'h9, 8'hFF);
      rd(4'h8, 8'h54);
      rd(4'h9, 8'h55);
      ctl_clear_enable <= '1;
      wr(4'h8, 8'hFF);
      wr(4'h9, 8'hFF);
      rd(4'h8, 8'h00);
      rd(4'h9, 8'h00);
      $display("test soft flags done");
      rd(4'hD, 8'h02);
      pulse(16'h0000, 1'b1, 1'b0);
      rd(4'h8, 8'h01);
      wr(4'h8, 8'h01);
      rd(4'h8, 8'h01);
      rd(4'hD, 8'h01);
      rd(4'hD, 8'h00);
      pulse(16'h0000, 1'b0, 1'b1);
      rd(4'h8, 8'h00);
      $display("test mailbox flag done");
      irq_is(1'b0);
      pulse(16'h0020, 1'b0, 1'b0);
      irq_is(1'b0);
      wr(4'hA, 8'h20);
      irq_is(1'b1);
      pulse(16'h0000, 1'b1, 1'b0);
      wr(4'hA, 8'h01);
      irq_is(1'b0);
      wr(4'hA, 8'h20);
      irq_is(1'b1);
      wr(4'h8, 8'h20);
      irq_is(1'b0);
      pulse(16'h1000, 1'b0, 1'b0);
      wr(4'hB, 8'h10);
      irq_is(1'b1);
      wr(4'h9, 8'h10);
      irq_is(1'b0);
      wr(4'hE, 8'h01);
      irq_is(1'b1);
      rd(4'hE, 8'h01);
      rd(4'hD, 8'h01);
      irq_is(1'b0);
      $display("test interrupt done");
      test_done();
   end
endmodule : hmw_window_tb
`default_nettype wire
